// File: include/amrc_pkg.sv
package amrc_pkg;
    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int DATA_W   = 16;
    localparam int WORD_W   = 32;
    localparam int ADDR_W   = 23;
    localparam int BANK_W   = 2;
    localparam int CS_W     = 4;
    localparam int CSSEL_W  = 2;
    localparam int TA_W     = 2;
    localparam int SETUP_W  = 4;
    localparam int STROBE_W = 6;
    localparam int HOLD_W   = 3;
    localparam int CNT_W    = 6;
    localparam int BEAT_W   = 2;

    // ----------------------------------------
    // Field positions of chip_select_config
    // ----------------------------------------
    localparam int CFG_W        = 32;
    localparam int CFG_TA_LSB   = 2;
    localparam int CFG_RHLD_LSB = 4;
    localparam int CFG_RSTB_LSB = 7;
    localparam int CFG_RSU_LSB  = 13;

    // ----------------------------------------
    // Bus widths selectable per access
    // ----------------------------------------
    localparam logic [1:0] WIDTH_8  = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;

    // ----------------------------------------
    // Reset and idle values, and the one-cycle turnaround count
    // ----------------------------------------
    localparam logic [CS_W-1:0]   CS_IDLE    = 4'hf;
    localparam logic [CNT_W-1:0]  CNT_ZERO   = 6'h00;
    localparam logic [BEAT_W-1:0] BEAT_ZERO  = 2'h0;
    localparam logic [CNT_W-1:0]  ONE_TA     = 6'h01;

    // ----------------------------------------
    // Sequencer states, one-hot
    // ----------------------------------------
    typedef enum logic [5:0] {
        AMRC_IDLE   = 6'h01,
        AMRC_TURN   = 6'h02,
        AMRC_SETUP  = 6'h04,
        AMRC_STROBE = 6'h08,
        AMRC_HOLD   = 6'h10,
        AMRC_DONE   = 6'h20
    } amrc_state_t;
endpackage

// File: rtl/amrc_read_seq.sv
// Behaviour
// R1 - Chip select falls at setup start unless already low from prior access
// R2 - Output enable falls at the first strobe cycle
// R3 - Output enable rises on the edge ending the strobe period
// R4 - Data bus is captured on that same strobe-ending edge
// R5 - Active wait input stretches the strobe period; memory may use it
// R6 - Address and bank address stop being held valid after hold
// R7 - Chip select rises after hold only when request is complete
// R8 - Follow-on narrow accesses re-enter setup at once, no turnaround
// R9 - Follow-on accesses keep the timing captured at the first access
// R10 - Request done and nothing pending: return to idle
// R11 - Pending request at completion goes straight into its turnaround
// R12 - Turnaround waits the configured turnaround count before setup
// R13 - Read after read inserts no turnaround cycles
// R14 - Read after write with zero turnaround inserts exactly one cycle
// R15 - Setup start loads read setup, strobe and hold from configuration
// R16 - Periods are counted in clock cycles and follow in order
module amrc_read_seq (
    input  wire logic                            clk_sys,
    input  wire logic                            rstn,
    input  wire logic                            req_valid,
    input  wire logic [amrc_pkg::ADDR_W-1:0]     req_address,
    input  wire logic [amrc_pkg::BANK_W-1:0]     req_bank,
    input  wire logic [amrc_pkg::CSSEL_W-1:0]    req_cs_sel,
    input  wire logic [1:0]                      req_bus_width,
    input  wire logic                            req_last_was_write,
    input  wire logic [amrc_pkg::CFG_W-1:0]      chip_select_config,
    input  wire logic [amrc_pkg::DATA_W-1:0]     ext_data_bus,
    input  wire logic                            ext_wait_request,
    output logic                                 req_accept,
    output logic                                 rd_valid,
    output logic [amrc_pkg::WORD_W-1:0]          rd_data,
    output logic                                 busy,
    output logic [amrc_pkg::CS_W-1:0]            ext_chip_select_n,
    output logic                                 ext_output_enable_n,
    output logic                                 ext_write_enable_n,
    output logic [amrc_pkg::ADDR_W-1:0]          ext_address,
    output logic [amrc_pkg::BANK_W-1:0]          ext_bank_address
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        amrc_pkg::amrc_state_t                   state;
        logic [amrc_pkg::CNT_W-1:0]              cnt;
        logic [amrc_pkg::SETUP_W-1:0]            setup;
        logic [amrc_pkg::STROBE_W-1:0]           strobe;
        logic [amrc_pkg::HOLD_W-1:0]             hold;
        logic [amrc_pkg::BEAT_W-1:0]             beat;
        logic [amrc_pkg::BEAT_W-1:0]             last_beat;
        logic [1:0]                              width;
        logic [amrc_pkg::CSSEL_W-1:0]            cs_sel;
        logic                                    prev_read;
        logic [amrc_pkg::WORD_W-1:0]             data;
        logic                                    accept;
        logic                                    rd_valid;
        logic                                    busy;
        logic [amrc_pkg::CS_W-1:0]               cs_n;
        logic                                    oe_n;
        logic [amrc_pkg::ADDR_W-1:0]             addr;
        logic [amrc_pkg::BANK_W-1:0]             bank;
    } amrc_regs_t;

    amrc_regs_t state_r;
    amrc_regs_t state_nxt;
    logic       rst_sync_n;

    amrc_reset_sync u_rst (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .rstn_sync (rst_sync_n)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [amrc_pkg::CS_W-1:0] cs_decode(
        input logic [amrc_pkg::CSSEL_W-1:0] sel
    );
        cs_decode = ~(4'h1 << sel);
    endfunction

    function automatic logic [amrc_pkg::CNT_W-1:0] turn_count(
        input logic [amrc_pkg::CFG_W-1:0] cfg,
        input logic                       prev_read,
        input logic                       last_write
    );
        logic [amrc_pkg::TA_W-1:0] ta;
        ta = cfg[amrc_pkg::CFG_TA_LSB +: amrc_pkg::TA_W];
        if (prev_read && !last_write) begin
            turn_count = amrc_pkg::CNT_ZERO;                       // R13
        end else if (last_write && ta == 2'h0) begin
            turn_count = amrc_pkg::ONE_TA;                         // R14
        end else begin
            turn_count = {{(amrc_pkg::CNT_W-amrc_pkg::TA_W){1'b0}}, ta}; // R12
        end
    endfunction

    function automatic logic [amrc_pkg::BEAT_W-1:0] beats_of(input logic [1:0] w);
        if (w == amrc_pkg::WIDTH_8) begin
            beats_of = 2'h3;
        end else if (w == amrc_pkg::WIDTH_16) begin
            beats_of = 2'h1;
        end else begin
            beats_of = 2'h0;
        end
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [amrc_pkg::CNT_W-1:0] tcnt;
        tcnt      = turn_count(chip_select_config, state_r.prev_read, req_last_was_write);
        state_nxt = state_r;
        state_nxt.accept   = 1'b0;
        state_nxt.rd_valid = 1'b0;
        unique case (state_r.state)
            amrc_pkg::AMRC_IDLE: begin
                state_nxt.busy = 1'b0;
                if (req_valid) begin
                    state_nxt.busy   = 1'b1;
                    state_nxt.cnt    = tcnt;
                    state_nxt.state  = amrc_pkg::AMRC_TURN;
                end
            end
            amrc_pkg::AMRC_TURN: begin
                if (state_r.cnt != amrc_pkg::CNT_ZERO) begin
                    state_nxt.cnt = state_r.cnt - 6'h01;           // R12
                end else if (!req_valid) begin
                    state_nxt.state = amrc_pkg::AMRC_IDLE;
                    state_nxt.busy  = 1'b0;
                end else begin
                    state_nxt.accept    = 1'b1;
                    state_nxt.setup     =
                        chip_select_config[amrc_pkg::CFG_RSU_LSB +: amrc_pkg::SETUP_W];   // R15
                    state_nxt.strobe    =
                        chip_select_config[amrc_pkg::CFG_RSTB_LSB +: amrc_pkg::STROBE_W]; // R15
                    state_nxt.hold      =
                        chip_select_config[amrc_pkg::CFG_RHLD_LSB +: amrc_pkg::HOLD_W];   // R15
                    state_nxt.cnt       = {2'h0,
                        chip_select_config[amrc_pkg::CFG_RSU_LSB +: amrc_pkg::SETUP_W]};
                    state_nxt.width     = req_bus_width;
                    state_nxt.last_beat = beats_of(req_bus_width);
                    state_nxt.beat      = amrc_pkg::BEAT_ZERO;
                    state_nxt.cs_sel    = req_cs_sel;
                    state_nxt.addr      = req_address;
                    state_nxt.bank      = req_bank;
                    state_nxt.data      = '0;
                    state_nxt.cs_n      = cs_decode(req_cs_sel);   // R1
                    state_nxt.state     = amrc_pkg::AMRC_SETUP;
                end
            end
            amrc_pkg::AMRC_SETUP: begin
                if (state_r.cnt != amrc_pkg::CNT_ZERO) begin
                    state_nxt.cnt = state_r.cnt - 6'h01;           // R16
                end else begin
                    state_nxt.oe_n  = 1'b0;                        // R2
                    state_nxt.cnt   = state_r.strobe;
                    state_nxt.state = amrc_pkg::AMRC_STROBE;
                end
            end
            amrc_pkg::AMRC_STROBE: begin
                if (ext_wait_request) begin
                    state_nxt.cnt = state_r.cnt;                   // R5
                end else if (state_r.cnt != amrc_pkg::CNT_ZERO) begin
                    state_nxt.cnt = state_r.cnt - 6'h01;           // R16
                end else begin
                    state_nxt.oe_n = 1'b1;                         // R3
                    if (state_r.width == amrc_pkg::WIDTH_8) begin
                        state_nxt.data[8*state_r.beat +: 8] = ext_data_bus[7:0]; // R4
                    end else if (state_r.width == amrc_pkg::WIDTH_16) begin
                        state_nxt.data[16*state_r.beat[0] +: 16] = ext_data_bus; // R4
                    end else begin
                        state_nxt.data[15:0] = ext_data_bus;       // R4
                    end
                    state_nxt.cnt   = {3'h0, state_r.hold};
                    state_nxt.state = amrc_pkg::AMRC_HOLD;
                end
            end
            amrc_pkg::AMRC_HOLD: begin
                if (state_r.cnt != amrc_pkg::CNT_ZERO) begin
                    state_nxt.cnt = state_r.cnt - 6'h01;           // R16
                end else if (state_r.beat != state_r.last_beat) begin
                    state_nxt.beat  = state_r.beat + 2'h1;         // R8
                    state_nxt.addr  = state_r.addr + 23'h000001;
                    state_nxt.cnt   = {2'h0, state_r.setup};       // R9
                    state_nxt.state = amrc_pkg::AMRC_SETUP;        // R8
                end else begin
                    state_nxt.cs_n      = amrc_pkg::CS_IDLE;       // R7
                    state_nxt.addr      = '0;                      // R6
                    state_nxt.bank      = '0;                      // R6
                    state_nxt.rd_valid  = 1'b1;
                    state_nxt.prev_read = 1'b1;
                    state_nxt.state     = amrc_pkg::AMRC_DONE;
                end
            end
            amrc_pkg::AMRC_DONE: begin
                if (req_valid) begin
                    state_nxt.cnt   = tcnt;                        // R11
                    state_nxt.state = amrc_pkg::AMRC_TURN;         // R11
                end else begin
                    state_nxt.busy  = 1'b0;                        // R10
                    state_nxt.state = amrc_pkg::AMRC_IDLE;         // R10
                end
            end
            default: begin
                state_nxt       = state_r;
                state_nxt.state = amrc_pkg::AMRC_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_r           <= '0;
            state_r.state     <= amrc_pkg::AMRC_IDLE;
            state_r.cs_n      <= amrc_pkg::CS_IDLE;
            state_r.oe_n      <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign req_accept          = state_r.accept;
    assign rd_valid            = state_r.rd_valid;
    assign rd_data             = state_r.data;
    assign busy                = state_r.busy;
    assign ext_chip_select_n   = state_r.cs_n;
    assign ext_output_enable_n = state_r.oe_n;
    assign ext_write_enable_n  = 1'b1;
    assign ext_address         = state_r.addr;
    assign ext_bank_address    = state_r.bank;
endmodule

// File: rtl/amrc_reset_sync.sv
module amrc_reset_sync (
    input  wire logic clk_sys,
    input  wire logic rstn,
    output logic      rstn_sync
);
    // ----------------------------------------
    // Two-stage reset release
    // ----------------------------------------
    logic meta_r;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta_r    <= 1'b0;
            rstn_sync <= 1'b0;
        end else begin
            meta_r    <= 1'b1;
            rstn_sync <= meta_r;
        end
    end
endmodule

// File: tb/amrc_mem_model.sv
// ----------------------------------------
// Asynchronous memory on the far side
// ----------------------------------------
module amrc_mem_model (
    input  wire logic                         clk_sys,
    input  wire logic [amrc_pkg::CS_W-1:0]    ext_chip_select_n,
    input  wire logic                         ext_output_enable_n,
    input  wire logic [amrc_pkg::ADDR_W-1:0]  ext_address,
    input  wire logic [7:0]                   wait_len,
    output logic      [amrc_pkg::DATA_W-1:0]  ext_data_bus,
    output logic                              ext_wait_request
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [amrc_pkg::DATA_W-1:0] last_r = 16'h0000;
    logic [7:0]                  cnt_r  = 8'h00;
    logic                        drive;
    assign drive = (ext_chip_select_n != amrc_pkg::CS_IDLE) && !ext_output_enable_n;
    // Released bus shows a toggling pattern
    assign ext_data_bus = drive ? {ext_address[7:0] ^ 8'hc3, ext_address[7:0]} : ~last_r;
    assign ext_wait_request = drive && (cnt_r < wait_len);
    always @(posedge clk_sys) begin
        last_r <= ext_data_bus;
        cnt_r  <= drive ? cnt_r + 8'h01 : 8'h00;
    end
endmodule

// File: tb/amrc_read_seq_checker.sv
module amrc_read_seq_checker (
    input wire logic                         clk_sys,
    input wire logic                         rstn,
    input wire logic                         req_valid,
    input wire logic                         req_accept,
    input wire logic                         rd_valid,
    input wire logic                         busy,
    input wire logic [amrc_pkg::CS_W-1:0]    ext_chip_select_n,
    input wire logic                         ext_output_enable_n,
    input wire logic                         ext_wait_request,
    input wire logic [amrc_pkg::ADDR_W-1:0]  ext_address,
    input wire logic [amrc_pkg::BANK_W-1:0]  ext_bank_address
);
    timeunit 1ns;
    timeprecision 100ps;
    logic idle;
    assign idle = (ext_chip_select_n == amrc_pkg::CS_IDLE);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    chk_cs_at_accept: assert property (req_accept |-> !idle && ext_output_enable_n)
        else $error("select not low at accept");
    chk_oe_under_cs: assert property (!ext_output_enable_n |-> !idle)
        else $error("strobe without select");
    chk_oe_rise_bound: assert property ($fell(ext_output_enable_n) |-> ##[1:200] ext_output_enable_n)
        else $error("strobe never ended");
    chk_wait_holds_oe: assert property (!ext_output_enable_n && ext_wait_request
        |=> !ext_output_enable_n)
        else $error("wait did not stretch strobe");
    chk_addr_idle: assert property (idle |-> ext_address == '0 && ext_bank_address == '0)
        else $error("address driven outside access");
    chk_addr_steady: assert property (!ext_output_enable_n && $past(!ext_output_enable_n)
        |-> $stable(ext_address))
        else $error("address moved in strobe");
    chk_cs_rise_done: assert property ($rose(idle) |-> rd_valid)
        else $error("select rose before request done");
    chk_valid_pulse: assert property (rd_valid |-> idle ##1 !rd_valid)
        else $error("read valid not a single pulse");
    chk_accept_cause: assert property (req_accept |-> $past(req_valid))
        else $error("accept without request");
    chk_busy_select: assert property (!idle |-> busy)
        else $error("select low while not busy");
    cover property (rd_valid);
    cover property (ext_wait_request && !ext_output_enable_n);
    cover property (req_accept);
    cover property (rd_valid && req_valid);
endmodule

bind amrc_read_seq amrc_read_seq_checker i_chk (
    .clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid), .req_accept(req_accept),
    .rd_valid(rd_valid), .busy(busy), .ext_chip_select_n(ext_chip_select_n),
    .ext_output_enable_n(ext_output_enable_n), .ext_wait_request(ext_wait_request),
    .ext_address(ext_address), .ext_bank_address(ext_bank_address)
);

// File: tb/async_memory_read_cycle_tb.sv
`define CHECK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module async_memory_read_cycle_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic                            clk_sys = 0, rstn = 0, req_valid = 0, req_last_was_write = 0;
    logic [amrc_pkg::ADDR_W-1:0]     req_address = '0, ext_address;
    logic [amrc_pkg::BANK_W-1:0]     req_bank = 2'h1, ext_bank_address, bank_seen;
    logic [amrc_pkg::CSSEL_W-1:0]    req_cs_sel = 2'h2;
    logic [1:0]                      req_bus_width = 2'h1;
    logic [amrc_pkg::CFG_W-1:0]      chip_select_config = '0;
    logic [amrc_pkg::DATA_W-1:0]     ext_data_bus;
    logic [amrc_pkg::WORD_W-1:0]     rd_data;
    logic [amrc_pkg::CS_W-1:0]       ext_chip_select_n, cs_seen;
    logic                            req_accept, rd_valid, busy, ext_output_enable_n;
    logic                            ext_write_enable_n, ext_wait_request, we_seen;
    logic [7:0]                      wait_len = 8'h00;
    int                              n_mismatch = 0, samples_checked = 0, cycles = 0;
    amrc_read_seq i_dut (.clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid),
        .req_address(req_address), .req_bank(req_bank), .req_cs_sel(req_cs_sel),
        .req_bus_width(req_bus_width), .req_last_was_write(req_last_was_write),
        .chip_select_config(chip_select_config), .ext_data_bus(ext_data_bus),
        .ext_wait_request(ext_wait_request), .req_accept(req_accept), .rd_valid(rd_valid),
        .rd_data(rd_data), .busy(busy), .ext_chip_select_n(ext_chip_select_n),
        .ext_output_enable_n(ext_output_enable_n), .ext_write_enable_n(ext_write_enable_n),
        .ext_address(ext_address), .ext_bank_address(ext_bank_address));
    amrc_mem_model i_mem (.clk_sys(clk_sys), .ext_chip_select_n(ext_chip_select_n),
        .ext_output_enable_n(ext_output_enable_n), .ext_address(ext_address),
        .wait_len(wait_len), .ext_data_bus(ext_data_bus), .ext_wait_request(ext_wait_request));
    // ----------------------------------------
    // Clock, timeout and verdict
    // ----------------------------------------
    initial forever #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [15:0] mword(input logic [22:0] a);
        return {a[7:0] ^ 8'hc3, a[7:0]};
    endfunction
    // ----------------------------------------
    // One read; timing fields cleared after accept
    // ----------------------------------------
    task automatic run_read(input logic [22:0] a, input logic [1:0] bw, input logic lw,
        input logic [1:0] ta, input logic [3:0] su, input logic [5:0] st,
        output int lat, output int oec, output logic [31:0] d);
        int i;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_address <= a;
        req_bus_width <= bw;
        req_last_was_write <= lw;
        chip_select_config <= {15'h0000, su, st, 3'h1, ta, 2'h0};
        lat = 0;
        oec = 0;
        for (i = 0; i < 60 && req_accept !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1 lat++;
        end
        @(posedge clk_sys);
        req_valid <= 1'b0;
        chip_select_config <= '0;
        for (i = 0; i < 900 && rd_valid !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1 if (ext_output_enable_n === 1'b0) begin
                oec++;
                cs_seen = ext_chip_select_n;
                bank_seen = ext_bank_address;
                we_seen = ext_write_enable_n;
            end
        end
        d = rd_data;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_turn;
        int l, o;
        logic [31:0] d;
        run_read(23'h10, amrc_pkg::WIDTH_16, 1'b1, 2'h0, 4'h1, 6'h02, l, o, d);
        `CHECK(l, 3)
        run_read(23'h20, amrc_pkg::WIDTH_16, 1'b1, 2'h3, 4'h1, 6'h02, l, o, d);
        `CHECK(l, 5)
        run_read(23'h30, amrc_pkg::WIDTH_16, 1'b0, 2'h3, 4'h1, 6'h02, l, o, d);
        `CHECK(l, 2)
        `CHECK(d, {mword(23'h31), mword(23'h30)})
        `CHECK(o, 6)
        `CHECK(cs_seen, 4'hb)
        `CHECK(bank_seen, 2'h1)
        `CHECK(we_seen, 1'b1)
        $display("turnaround test done");
    endtask
    task automatic t_narrow;
        int l, o, k;
        logic [31:0] d, e;
        logic [15:0] m;
        for (k = 0; k < 4; k++) begin
            m = mword(23'h7e + 23'(k));
            e[8*k +: 8] = m[7:0];
        end
        run_read(23'h7e, amrc_pkg::WIDTH_8, 1'b0, 2'h2, 4'h2, 6'h03, l, o, d);
        `CHECK(d, e)
        `CHECK(o, 16)
        $display("narrow test done");
    endtask
    task automatic t_wait;
        int l, o;
        logic [31:0] d;
        wait_len <= 8'h03;
        run_read(23'h40, amrc_pkg::WIDTH_16, 1'b0, 2'h0, 4'h1, 6'h01, l, o, d);
        wait_len <= 8'h00;
        `CHECK(o, 10)
        `CHECK(d, {mword(23'h41), mword(23'h40)})
        $display("wait test done");
    endtask
    task automatic t_chain;
        int i, t_done, t_acc;
        t_done = -1;
        t_acc = -1;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_address <= 23'h50;
        req_bus_width <= 2'h2;
        req_last_was_write <= 1'b0;
        chip_select_config <= 32'h0000_000c;
        for (i = 0; i < 100 && t_acc < 0; i++) begin
            @(posedge clk_sys);
            #1 if (rd_valid === 1'b1) t_done = i;
            if (t_done >= 0 && req_accept === 1'b1) t_acc = i;
        end
        @(posedge clk_sys);
        req_valid <= 1'b0;
        for (i = 0; i < 100 && rd_valid !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        `CHECK(t_acc - t_done, 2)
        `CHECK(rd_data, {16'h0000, mword(23'h50)})
        $display("chain test done");
    endtask
    task automatic t_abandon;
        int acc;
        acc = 0;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_last_was_write <= 1'b1;
        chip_select_config <= 32'h0000_200c;
        repeat (2) @(posedge clk_sys);
        req_valid <= 1'b0;
        repeat (12) begin
            @(posedge clk_sys);
            #1 if (req_accept === 1'b1) acc++;
        end
        `CHECK(acc, 0)
        `CHECK(ext_chip_select_n, amrc_pkg::CS_IDLE)
        $display("abandon test done");
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_turn();
        t_narrow();
        t_wait();
        t_chain();
        t_abandon();
        print_verdict();
    end
endmodule
